// *** hw/liuck_top.sv ***
`timescale 1ns/1ps
`include "liuck_regs.svh"

module liuck_top (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [9:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output      logic [31:0]          wb_dat_o,
  output      logic                 wb_ack_o,
  input  wire liuck_pkg::liuck_line_t line_i,
  input  wire logic                 oe_pin_i,
  input  wire logic                 rx_edge_select_pin_i,
  input  wire logic                 irq_req_i,
  output      logic [1:0]           ja_bandwidth_sel_o,
  output      logic                 hitless_rx_impedance_off_o,
  output      logic [7:0]           tester_enable_o,
  output      logic [7:0]           violation_insert_trigger_o,
  output      logic [7:0]           rx_clock_falling_o,
  output      logic [7:0]           tx_clock_invert_o,
  output      logic [2:0]           pll_ref_channel_sel_o,
  output      logic                 pll_use_recovered_o,
  output      logic                 pll_enable_o,
  output      logic                 mclk_base_sel_o,
  output      logic [1:0]           mclk_multiple_sel_o,
  output      logic                 rate_clock_sel_o,
  output      logic [3:0]           aux_clock_freq_sel_o,
  output      logic [7:0]           rx_clock_hold_low_o,
  output      logic [7:0]           rx_clock_to_mclk_o,
  output      logic                 irq_n_pin_o,
  output      logic                 irq_n_pin_oe_o
);

  // Pick one bit of a channel vector
  function automatic logic pick_bit(
    input logic [7:0] vec,
    input logic [2:0] sel
  );
    pick_bit = vec[sel];
  endfunction : pick_bit

  // Registered state and its next value
  liuck_pkg::liuck_state_t s_q;
  liuck_pkg::liuck_state_t s_d;

  logic [7:0] idx;     // Register index from the byte address
  logic       req;     // New bus request this cycle
  logic       rd;      // Read request
  logic       wr;      // Write request on lane 0
  logic       liu;     // Bank pointer opens this bank
  logic [7:0] wd;      // Write data byte
  logic [7:0] ev;      // Qualified violation per channel
  logic [7:0] lv_clr;  // Status bits cleared by the bus

  // Bus decode
  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign rd  = req & ~wb_we_i;
  assign wr  = req & wb_we_i & wb_sel_i[0];
  assign liu = (s_q.bank == `LIUCK_BANK_LIU);
  assign wd  = wb_dat_i[7:0];

  // Next-state logic for bus, status and line-side outputs
  always_comb
  begin
    s_d    = s_q;
    ev     = `LIUCK_BYTE_ZERO;
    lv_clr = `LIUCK_BYTE_ZERO;
    // Answer every request one cycle later
    s_d.ack = req;
    if (req)
    begin
      s_d.rdata = `LIUCK_BYTE_ZERO;
      // Bank pointer is always reachable
      if (idx == `LIUCK_IDX_BANK)
      begin
        s_d.rdata = s_q.bank;
        if (wr)
          s_d.bank = wd;
      end
      // Rest of the bank only when opened
      else if (liu)
      begin
        case (idx)
          `LIUCK_IDX_GLB:
          begin
            s_d.rdata[`LIUCK_GLB_JABW] = s_q.ja_bw;
            s_d.rdata[`LIUCK_GLB_HIT]  = s_q.hit;
            if (wr)
            begin
              s_d.ja_bw = wd[`LIUCK_GLB_JABW];
              s_d.hit   = wd[`LIUCK_GLB_HIT];
            end
          end
          `LIUCK_IDX_TST:
          begin
            s_d.rdata[`LIUCK_TST_SEL] = s_q.tsel;
            s_d.rdata[`LIUCK_TST_EN]  = s_q.ten;
            if (wr)
            begin
              s_d.tsel = wd[`LIUCK_TST_SEL];
              s_d.ten  = wd[`LIUCK_TST_EN];
            end
          end
          `LIUCK_IDX_VINS:
          begin
            s_d.rdata = s_q.vi;
            if (wr)
              s_d.vi = wd;
          end
          `LIUCK_IDX_VST:
          begin
            s_d.rdata = s_q.vstat;
            // Read clears what was shown
            if (rd && !s_q.cow_en)
              lv_clr = s_q.vstat;
            // Write of ones clears
            if (wr && s_q.cow_en)
              lv_clr = wd;
          end
          `LIUCK_IDX_RCKI:
          begin
            s_d.rdata = s_q.rcki;
            if (wr)
              s_d.rcki = wd;
          end
          `LIUCK_IDX_TCKI:
          begin
            s_d.rdata = s_q.tcki;
            if (wr)
              s_d.tcki = wd;
          end
          `LIUCK_IDX_CKC:
          begin
            s_d.rdata[`LIUCK_CKC_PLLCH] = s_q.pll_ch;
            s_d.rdata[`LIUCK_CKC_RATE]  = s_q.rate_sel;
            s_d.rdata[`LIUCK_CKC_AUX]   = s_q.aux_sel;
            if (wr)
            begin
              s_d.pll_ch   = wd[`LIUCK_CKC_PLLCH];
              s_d.rate_sel = wd[`LIUCK_CKC_RATE];
              s_d.aux_sel  = wd[`LIUCK_CKC_AUX];
            end
          end
          `LIUCK_IDX_GATE:
          begin
            s_d.rdata = s_q.gate;
            if (wr)
              s_d.gate = wd;
          end
          `LIUCK_IDX_EZD:
          begin
            s_d.rdata = s_q.ezd;
            if (wr)
              s_d.ezd = wd;
          end
          `LIUCK_IDX_CVOFF:
          begin
            s_d.rdata = s_q.cvoff;
            if (wr)
              s_d.cvoff = wd;
          end
          `LIUCK_IDX_SRM:
          begin
            s_d.rdata = s_q.srm;
            if (wr)
              s_d.srm = wd;
          end
          `LIUCK_IDX_AMI:
          begin
            s_d.rdata = s_q.ami;
            if (wr)
              s_d.ami = wd;
          end
          `LIUCK_IDX_MCLK:
          begin
            s_d.rdata[`LIUCK_MCLK_REFSRC] = s_q.ref_src;
            s_d.rdata[`LIUCK_MCLK_MULT]   = s_q.mult;
            s_d.rdata[`LIUCK_MCLK_BASE]   = s_q.base_sel;
            s_d.rdata[`LIUCK_MCLK_PLLON]  = s_q.pll_en;
            if (wr)
            begin
              s_d.ref_src  = wd[`LIUCK_MCLK_REFSRC];
              s_d.mult     = wd[`LIUCK_MCLK_MULT];
              s_d.base_sel = wd[`LIUCK_MCLK_BASE];
              s_d.pll_en   = wd[`LIUCK_MCLK_PLLON];
            end
          end
          `LIUCK_IDX_IRQ:
          begin
            s_d.rdata[`LIUCK_IRQ_MODE] = s_q.irq_mode;
            s_d.rdata[`LIUCK_IRQ_COW]  = s_q.cow_en;
            if (wr)
            begin
              s_d.irq_mode = wd[`LIUCK_IRQ_MODE];
              s_d.cow_en   = wd[`LIUCK_IRQ_COW];
            end
          end
          // Unmapped index reads zero, write ignored
          default:
            s_d.rdata = `LIUCK_BYTE_ZERO;
        endcase
      end
    end

    // Violation capture per channel
    for (int i = 0; i < 8; i++)
    begin
      // Dual rail passes only bipolar violations
      ev[i] = line_i.bpv[i] | (s_q.srm[i] & (
              (line_i.exz[i] & s_q.ezd[i]) |
              (line_i.cv[i] & ~s_q.ami[i] & ~s_q.cvoff[i])));
      // Window after a capture blocks later events
      if (s_q.win[i] != `LIUCK_WIN_IDLE)
      begin
        s_d.win[i]   = s_q.win[i] - `LIUCK_WIN_STEP;
        s_d.vstat[i] = s_q.vstat[i] & ~lv_clr[i];
      end
      else if (ev[i])
      begin
        // Set wins over a clear in the same cycle
        s_d.win[i]   = `LIUCK_WIN_HOLD;
        s_d.vstat[i] = 1'b1;
      end
      // No event: only the bus may clear
      else
        s_d.vstat[i] = s_q.vstat[i] & ~lv_clr[i];
    end

    // Insert pulse on a rising insert bit
    s_d.vi_prev = s_q.vi;
    s_d.vi_pls  = s_q.vi & ~s_q.vi_prev;

    // Impedance off only while OE pin is low
    s_d.hit_o = s_q.hit & ~oe_pin_i;

    // One-hot tester enable from channel select
    s_d.ten_o = s_q.ten ? (`LIUCK_ONE_HOT << s_q.tsel)
                        : `LIUCK_BYTE_ZERO;

    // Edge pin forces falling-edge receive data
    s_d.rxf = s_q.rcki | {8{rx_edge_select_pin_i}};

    // Recovered reference unless its channel lost signal
    s_d.pll_rec = s_q.ref_src &
                  ~pick_bit(line_i.los, s_q.pll_ch);

    // Recovered clock handling on loss
    s_d.hold   = s_q.gate & line_i.los;
    s_d.tomclk = ~s_q.gate & line_i.los;

    // Interrupt pin: low when active, idle per mode
    s_d.irq_out = ~((|s_q.vstat) | irq_req_i);
    s_d.irq_oe  = (|s_q.vstat) | irq_req_i | s_q.irq_mode;
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      s_q <= `LIUCK_RST;
    else if (ce_i)
      s_q <= s_d;
  end

  // Outputs straight from the state register
  assign wb_dat_o                   = {`LIUCK_PAD_ZERO, s_q.rdata};
  assign wb_ack_o                   = s_q.ack;
  assign ja_bandwidth_sel_o         = s_q.ja_bw;
  assign hitless_rx_impedance_off_o = s_q.hit_o;
  assign tester_enable_o            = s_q.ten_o;
  assign violation_insert_trigger_o = s_q.vi_pls;
  assign rx_clock_falling_o         = s_q.rxf;
  assign tx_clock_invert_o          = s_q.tcki;
  assign pll_ref_channel_sel_o      = s_q.pll_ch;
  assign pll_use_recovered_o        = s_q.pll_rec;
  assign pll_enable_o               = s_q.pll_en;
  assign mclk_base_sel_o            = s_q.base_sel;
  assign mclk_multiple_sel_o        = s_q.mult;
  assign rate_clock_sel_o           = s_q.rate_sel;
  assign aux_clock_freq_sel_o       = s_q.aux_sel;
  assign rx_clock_hold_low_o        = s_q.hold;
  assign rx_clock_to_mclk_o         = s_q.tomclk;
  assign irq_n_pin_o                = s_q.irq_out;
  assign irq_n_pin_oe_o             = s_q.irq_oe;

  // Closed bank reads zero
  property p_bank_closed;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && req && !wb_we_i && !liu && idx != `LIUCK_IDX_BANK)
    |=> (wb_ack_o && wb_dat_o == '0);
  endproperty
  a_bank_closed: assert property (p_bank_closed)
    else $error("closed bank returned data");

  // Rising insert bit gives exactly one pulse
  property p_insert_pulse;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_q.vi[0] && !s_q.vi_prev[0])
    |=> violation_insert_trigger_o[0] ##1 (!ce_i ||
        !violation_insert_trigger_o[0]);
  endproperty
  a_insert_pulse: assert property (p_insert_pulse)
    else $error("insert pulse wrong");

  // First qualified event latches status
  property p_latch;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && line_i.bpv[0] && s_q.win[0] == `LIUCK_WIN_IDLE)
    |=> s_q.vstat[0];
  endproperty
  a_latch: assert property (p_latch)
    else $error("violation not latched");

  // No second capture within the window
  property p_window;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_q.win[0] != `LIUCK_WIN_IDLE && !s_q.vstat[0])
    |=> !s_q.vstat[0];
  endproperty
  a_window: assert property (p_window)
    else $error("capture inside window");

  // Dual rail ignores non-bipolar events
  property p_dual_rail;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && !s_q.srm[0] && !line_i.bpv[0] && !s_q.vstat[0])
    |=> !s_q.vstat[0];
  endproperty
  a_dual_rail: assert property (p_dual_rail)
    else $error("non-bipolar event latched");

  // Tester active on at most one channel
  property p_one_tester;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_q.ten) |=> $onehot(tester_enable_o);
  endproperty
  a_one_tester: assert property (p_one_tester)
    else $error("tester not one-hot");

  // Edge pin forces all channels falling
  property p_edge_pin;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && rx_edge_select_pin_i) |=> (&rx_clock_falling_o);
  endproperty
  a_edge_pin: assert property (p_edge_pin)
    else $error("edge pin ignored");

  // Loss on reference channel drops recovered clock
  property p_ref_loss;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && pick_bit(line_i.los, s_q.pll_ch))
    |=> !pll_use_recovered_o;
  endproperty
  a_ref_loss: assert property (p_ref_loss)
    else $error("reference kept during loss");

  // Gated clock held low, not switched
  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && s_q.gate[0] && line_i.los[0])
    |=> (rx_clock_hold_low_o[0] && !rx_clock_to_mclk_o[0]);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate on loss wrong");

  // Active interrupt drives the pin low
  property p_irq;
    @(posedge clk_i) disable iff (rst_i)
    (ce_i && irq_req_i) |=> (irq_n_pin_oe_o && !irq_n_pin_o);
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt pin not driven low");

endmodule : liuck_top

// *** hw/liuck_regs.svh ***
`ifndef LIUCK_REGS_SVH
`define LIUCK_REGS_SVH

// Register indexes; byte address is four times the index
`define LIUCK_IDX_GLB     8'h07
`define LIUCK_IDX_TST     8'h10
`define LIUCK_IDX_VINS    8'h11
`define LIUCK_IDX_VST     8'h12
`define LIUCK_IDX_RCKI    8'h13
`define LIUCK_IDX_TCKI    8'h14
`define LIUCK_IDX_CKC     8'h15
`define LIUCK_IDX_GATE    8'h16
`define LIUCK_IDX_EZD     8'h18
`define LIUCK_IDX_CVOFF   8'h19
`define LIUCK_IDX_SRM     8'h1A
`define LIUCK_IDX_AMI     8'h1B
`define LIUCK_IDX_MCLK    8'h1C
`define LIUCK_IDX_IRQ     8'h1E
`define LIUCK_IDX_BANK    8'h1F

// Bank pointer value that opens this bank
`define LIUCK_BANK_LIU    8'h01

// Field positions
`define LIUCK_GLB_HIT     0
`define LIUCK_GLB_JABW    2:1
`define LIUCK_TST_EN      0
`define LIUCK_TST_SEL     7:5
`define LIUCK_CKC_AUX     3:0
`define LIUCK_CKC_RATE    4
`define LIUCK_CKC_PLLCH   7:5
`define LIUCK_IRQ_COW     0
`define LIUCK_IRQ_MODE    1
`define LIUCK_MCLK_PLLON  0
`define LIUCK_MCLK_BASE   1
`define LIUCK_MCLK_MULT   3:2
`define LIUCK_MCLK_REFSRC 6

// Reset values and counts
`define LIUCK_RST         '0
`define LIUCK_BYTE_ZERO   8'h00
`define LIUCK_PAD_ZERO    24'h00_0000
`define LIUCK_WIN_IDLE    2'h0
`define LIUCK_WIN_STEP    2'h1
`define LIUCK_WIN_HOLD    2'h2
`define LIUCK_ONE_HOT     8'h01

`endif

// *** hw/liuck_pkg.sv ***
package liuck_pkg;

  // Per-channel line events from the receivers
  typedef struct packed {
    logic [7:0] bpv;     // Bipolar violation seen
    logic [7:0] cv;      // Code violation seen
    logic [7:0] exz;     // Excessive zeros seen
    logic [7:0] los;     // Loss of signal
  } liuck_line_t;

  // Whole state of the register bank
  typedef struct packed {
    logic            ack;
    logic [7:0]      rdata;
    logic [7:0]      bank;
    logic [1:0]      ja_bw;
    logic            hit;
    logic [2:0]      tsel;
    logic            ten;
    logic [7:0]      vi;
    logic [7:0]      vi_prev;
    logic [7:0]      vi_pls;
    logic [7:0]      vstat;
    logic [7:0][1:0] win;
    logic [7:0]      rcki;
    logic [7:0]      tcki;
    logic [2:0]      pll_ch;
    logic            rate_sel;
    logic [3:0]      aux_sel;
    logic [7:0]      gate;
    logic            irq_mode;
    logic            cow_en;
    logic [7:0]      ezd;
    logic [7:0]      cvoff;
    logic [7:0]      srm;
    logic [7:0]      ami;
    logic            pll_en;
    logic            base_sel;
    logic [1:0]      mult;
    logic            ref_src;
    logic            hit_o;
    logic [7:0]      ten_o;
    logic [7:0]      rxf;
    logic            pll_rec;
    logic [7:0]      hold;
    logic [7:0]      tomclk;
    logic            irq_out;
    logic            irq_oe;
  } liuck_state_t;

endpackage : liuck_pkg

// *** verif/liuck_host.sv ***
`timescale 1ns/1ps
// Host processor model: Wishbone classic master for the register bank
module liuck_host (
  input  wire logic        clk_i,
  output      logic        wb_cyc_o,
  output      logic        wb_stb_o,
  output      logic        wb_we_o,
  output      logic [9:0]  wb_adr_o,
  output      logic [3:0]  wb_sel_o,
  output      logic [31:0] wb_dat_o,
  input  wire logic        wb_ack_i,
  input  wire logic [31:0] wb_dat_i
);
  // Idle bus from time zero
  initial
  begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o  = 1'b0;
    wb_adr_o = 10'h000;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  // One classic cycle, held until ack is sampled high
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o  <= we;
    wb_sel_o <= 4'hF;
    wb_adr_o <= {idx, 2'b00};
    wb_dat_o <= {24'h00_0000, wd};
    // Wait for the answer; only the bench watchdog ends a hang
    do
      @(posedge clk_i);
    while (wb_ack_i !== 1'b1);
    rd = wb_dat_i;
    // Released lines no longer show the old value
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o  <= 1'b0;
    wb_adr_o <= ~wb_adr_o;
    wb_dat_o <= ~wb_dat_o;
  endtask : xfer
endmodule : liuck_host

// *** verif/tb_liu_clock_and_test_control_regs.sv ***
`timescale 1ns/1ps
`include "liuck_regs.svh"
module tb_liu_clock_and_test_control_regs;
  logic        clk, rst, oe_pin, edge_pin, irq_req; // Clock, reset and pins
  logic [23:0] ev;                                  // Event pulses bpv, cv, exz
  logic [7:0]  los;                                 // Loss of signal levels
  logic        cyc, stb, we, ack;                   // Bus handshake
  logic [9:0]  adr;                                 // Byte address
  logic [3:0]  sel;                                 // Byte enables
  logic [31:0] dat_w, dat_r, rdat;                  // Bus data
  logic [1:0]  ja_bw, mult;                         // Code outputs
  logic        hit_off, use_rec, pll_enable, base, rate, irq_n, irq_oe;
  logic [7:0]  ten, vtrig, rxf, tcki, hold, tomclk;
  logic [2:0]  pll_ch;                              // Reference channel
  logic [3:0]  aux;                                 // Auxiliary clock code
  int          error_cnt, tests_run, trig_cnt;      // Counters
  logic [7:0]  regs [9] = '{`LIUCK_IDX_GLB, `LIUCK_IDX_TST, `LIUCK_IDX_VINS,
    `LIUCK_IDX_VST, `LIUCK_IDX_RCKI, `LIUCK_IDX_TCKI, `LIUCK_IDX_CKC,
    `LIUCK_IDX_GATE, `LIUCK_IDX_IRQ};

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  liuck_host liuck_host_inst (.clk_i(clk), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
    .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dat_w), .wb_ack_i(ack), .wb_dat_i(dat_r));

  liuck_top liuck_top_inst (.clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .line_i({ev, los}), .oe_pin_i(oe_pin),
    .rx_edge_select_pin_i(edge_pin), .irq_req_i(irq_req), .ja_bandwidth_sel_o(ja_bw),
    .hitless_rx_impedance_off_o(hit_off), .tester_enable_o(ten),
    .violation_insert_trigger_o(vtrig), .rx_clock_falling_o(rxf),
    .tx_clock_invert_o(tcki), .pll_ref_channel_sel_o(pll_ch),
    .pll_use_recovered_o(use_rec), .pll_enable_o(pll_enable), .mclk_base_sel_o(base),
    .mclk_multiple_sel_o(mult), .rate_clock_sel_o(rate), .aux_clock_freq_sel_o(aux),
    .rx_clock_hold_low_o(hold), .rx_clock_to_mclk_o(tomclk), .irq_n_pin_o(irq_n),
    .irq_n_pin_oe_o(irq_oe));

  // Count cycles with channel 0 insert trigger high
  always @(posedge clk)
    if (vtrig[0] === 1'b1)
      trig_cnt++;

  // Compare and report
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    liuck_host_inst.xfer(1'b1, i, d, rdat);
  endtask : wr

  task automatic rchk(input logic [7:0] i, input logic [7:0] e);
    liuck_host_inst.xfer(1'b0, i, 8'h00, rdat);
    chk(rdat, {24'h00_0000, e});
  endtask : rchk

  // Let registered outputs land
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  // One-cycle line event
  task automatic pulse(input logic [23:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 24'h00_0000;
  endtask : pulse

  // Closed bank, then reset values and an unmapped place
  task automatic t_bank;
    rchk(`LIUCK_IDX_BANK, 8'h00);
    wr(`LIUCK_IDX_GLB, 8'h07);
    rchk(`LIUCK_IDX_GLB, 8'h00);
    wr(`LIUCK_IDX_BANK, `LIUCK_BANK_LIU);
    foreach (regs[i])
      rchk(regs[i], 8'h00);
    rchk(8'h17, 8'h00);
  endtask : t_bank

  // Bandwidth codes, hitless control and tester select
  task automatic t_cfg;
    for (int i = 0; i < 4; i++)
    begin
      wr(`LIUCK_IDX_GLB, {5'b0_0000, i[1:0], 1'b1});
      settle;
      chk(32'(ja_bw), 32'(i[1:0]));
      chk(32'(hit_off), 32'h0000_0001);
    end
    @(posedge clk);
    oe_pin <= 1'b1;
    settle;
    chk(32'(hit_off), 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      wr(`LIUCK_IDX_TST, {i[2:0], 5'b0_0001});
      settle;
      chk(32'(ten), 32'(8'h01 << i));
    end
    wr(`LIUCK_IDX_TST, 8'hE0);
    settle;
    chk(32'(ten), 32'h0000_0000);
  endtask : t_cfg

  // One insertion per rising insert bit
  task automatic t_insert;
    int c0;
    c0 = trig_cnt;
    wr(`LIUCK_IDX_VINS, 8'h01);
    wr(`LIUCK_IDX_VINS, 8'h01);
    settle;
    chk(32'(trig_cnt - c0), 32'h0000_0001);
    wr(`LIUCK_IDX_VINS, 8'h00);
    wr(`LIUCK_IDX_VINS, 8'h01);
    settle;
    chk(32'(trig_cnt - c0), 32'h0000_0002);
  endtask : t_insert

  // Status latch, qualifiers, window and clearing
  task automatic t_status;
    pulse({8'h01, 8'h02, 8'h04});
    rchk(`LIUCK_IDX_VST, 8'h01);
    rchk(`LIUCK_IDX_VST, 8'h00);
    wr(`LIUCK_IDX_SRM, 8'hFF);
    wr(`LIUCK_IDX_EZD, 8'h04);
    wr(`LIUCK_IDX_CVOFF, 8'h08);
    pulse({8'h00, 8'h0A, 8'h14});
    rchk(`LIUCK_IDX_VST, 8'h06);
    wr(`LIUCK_IDX_AMI, 8'h02);
    pulse({8'h00, 8'h02, 8'h00});
    rchk(`LIUCK_IDX_VST, 8'h00);
    // Second event inside the window, after the clearing read
    @(posedge clk);
    ev <= {8'h04, 16'h0000};
    fork
      rchk(`LIUCK_IDX_VST, 8'h04);
      begin
        @(posedge clk);
        ev <= 24'h00_0000;
        @(posedge clk);
        ev <= {8'h04, 16'h0000};
        @(posedge clk);
        ev <= 24'h00_0000;
      end
    join
    rchk(`LIUCK_IDX_VST, 8'h00);
    wr(`LIUCK_IDX_IRQ, 8'h01);
    pulse({8'h80, 16'h0000});
    rchk(`LIUCK_IDX_VST, 8'h80);
    rchk(`LIUCK_IDX_VST, 8'h80);
    settle;
    chk(32'({irq_n, irq_oe}), 32'h0000_0001);
    wr(`LIUCK_IDX_VST, 8'h7F);
    rchk(`LIUCK_IDX_VST, 8'h80);
    wr(`LIUCK_IDX_VST, 8'h80);
    rchk(`LIUCK_IDX_VST, 8'h00);
    settle;
    chk(32'(irq_oe), 32'h0000_0000);
    wr(`LIUCK_IDX_IRQ, 8'h03);
    settle;
    chk(32'({irq_n, irq_oe}), 32'h0000_0003);
    @(posedge clk);
    irq_req <= 1'b1;
    settle;
    chk(32'({irq_n, irq_oe}), 32'h0000_0001);
  endtask : t_status

  // Clock inversion, selection, fallback and gating
  task automatic t_clocks;
    wr(`LIUCK_IDX_RCKI, 8'hA5);
    wr(`LIUCK_IDX_TCKI, 8'h3C);
    rchk(`LIUCK_IDX_RCKI, 8'hA5);
    settle;
    chk(32'(rxf), 32'h0000_00A5);
    chk(32'(tcki), 32'h0000_003C);
    @(posedge clk);
    edge_pin <= 1'b1;
    settle;
    chk(32'(rxf), 32'h0000_00FF);
    for (int i = 0; i < 16; i++)
    begin
      wr(`LIUCK_IDX_CKC, {i[2:0], i[0], i[3:0]});
      settle;
      chk(32'(aux), 32'(i[3:0]));
      chk(32'(pll_ch), 32'(i[2:0]));
      chk(32'(rate), 32'(i[0]));
    end
    wr(`LIUCK_IDX_MCLK, 8'h4D);
    settle;
    chk(32'({pll_enable, base, mult}), 32'h0000_000B);
    chk(32'(use_rec), 32'h0000_0001);
    @(posedge clk);
    los <= 8'h80;
    settle;
    chk(32'(use_rec), 32'h0000_0000);
    @(posedge clk);
    los <= 8'h40;
    settle;
    chk(32'(use_rec), 32'h0000_0001);
    wr(`LIUCK_IDX_GATE, 8'h0F);
    @(posedge clk);
    los <= 8'h11;
    settle;
    chk(32'({hold, tomclk}), 32'h0000_0110);
  endtask : t_clocks

  // Counts and verdict
  task automatic wrap_up;
    $display("Errors %0d, comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial
  begin
    rst = 1'b1;
    oe_pin = 1'b0;
    edge_pin = 1'b0;
    irq_req = 1'b0;
    ev = 24'h00_0000;
    los = 8'h00;
    error_cnt = 0;
    tests_run = 0;
    trig_cnt = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_bank;
    t_cfg;
    t_insert;
    t_status;
    t_clocks;
    wrap_up;
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    wrap_up;
  end
endmodule : tb_liu_clock_and_test_control_regs
